// *** src/sss_switch_status.sv ***
`timescale 1ns/1ps
`include "sss_cfg.svh"

// Summary of operation
// [R1] Bits 2:0 report the operating-mode strap; 0 normal, 1-3 with EEPROM init.
// [R2] Bit 5 holds the downstream common-clock strap captured in fundamental reset.
// [R3] Bit 6 holds the upstream common-clock strap captured in fundamental reset.
// [R4] Bit 7 holds the two-wire slow-mode strap captured in fundamental reset.
// [R5] Bit 8 holds the reference-clock mode strap captured in fundamental reset.
// [R6] Bit 9 holds the reset-halt strap captured in fundamental reset.
// [R7] Bits 22:20 show upstream lock state, reset 0 meaning unlocked.
// [R8] Marker bits 31:28 reset to zero and survive hot reset.
// [R9] Reduced-latency mode selects the alternate elastic FIFO initial value.
// [R10] System picks reduced latency only with common clock or payload below 2 KB.
// [R11] Marker accepts writes only while the register unlock bit 3 is set.
// [R12] Reserved bits read zero; writes to them and status fields do nothing.

module sss_switch_status #(
    parameter int         EFIFO_W       = 4,
    parameter logic [3:0] EFIFO_NORMAL  = `SSS_EFIFO_NORMAL,
    parameter logic [3:0] EFIFO_REDUCED = `SSS_EFIFO_REDUCED
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic      [31:0]        hrdata,
    output logic                    hresp,
    // Strap pins
    input  wire logic [2:0]         operating_mode_strap,
    input  wire logic               common_clock_down,
    input  wire logic               common_clock_up,
    input  wire logic               master_twowire_slow,
    input  wire logic               refclk_mode_select,
    input  wire logic               reset_halt_strap,
    // Switch core
    input  wire logic               hot_reset,
    input  wire logic [2:0]         upstream_lock_state,
    output logic      [EFIFO_W-1:0] elastic_fifo_initial_value
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (EFIFO_W < 1 || EFIFO_W > 4) begin : g_chk
        $error("sss_switch_status: EFIFO_W must be 1 to 4");
    end

    // ****************************************
    // Strap synchronisation and capture
    // ****************************************
    sss_pkg::sss_strap_s strap_pins;
    sss_pkg::sss_strap_s strap_sync;
    sss_pkg::sss_strap_s strap_ff;
    sss_pkg::sss_strap_s nxt_strap;

    always_comb begin
        strap_pins.operating_mode_strap = operating_mode_strap;
        strap_pins.common_clock_down    = common_clock_down;
        strap_pins.common_clock_up      = common_clock_up;
        strap_pins.master_twowire_slow  = master_twowire_slow;
        strap_pins.refclk_mode_select   = refclk_mode_select;
        strap_pins.reset_halt_strap     = reset_halt_strap;
    end

    sss_sync #(
        .WIDTH ($bits(sss_pkg::sss_strap_s))
    ) u_strap_sync (
        .ref_clk  (ref_clk),
        .async_in (strap_pins),
        .sync_out (strap_sync)
    );

    // Follow pins while in fundamental reset, freeze on release
    always_comb begin
        nxt_strap = strap_ff;
        if (!rstn) begin
            nxt_strap = strap_sync; // [R1] [R2] [R3] [R4] [R5] [R6]
        end
    end

    always_ff @(posedge ref_clk) begin
        strap_ff <= nxt_strap;
    end

    // ****************************************
    // Lock state, marker and unlock control
    // ****************************************
    logic [2:0]         lock_ff;
    logic [2:0]         nxt_lock;
    logic [3:0]         marker_ff;
    logic [3:0]         nxt_marker;
    logic               unlock_ff;
    logic               nxt_unlock;
    logic [EFIFO_W-1:0] efifo_ff;
    logic [EFIFO_W-1:0] nxt_efifo;
    logic               wr_pend_ff;
    logic [11:0]        wr_addr_ff;
    logic               wr_status;
    logic               wr_unlock;

    always_comb begin
        wr_status = wr_pend_ff && (wr_addr_ff[11:2] == `SSS_STATUS_OFF >> 2);
        wr_unlock = wr_pend_ff && (wr_addr_ff[11:2] == `SSS_UNLOCK_OFF >> 2);
    end

    always_comb begin
        nxt_lock   = upstream_lock_state; // [R7]
        nxt_marker = marker_ff;
        nxt_unlock = unlock_ff;
        // Hot reset leaves the marker alone
        if (wr_status && unlock_ff) begin
            nxt_marker = hwdata[`SSS_MARKER_MSB:`SSS_MARKER_LSB]; // [R8] [R11]
        end
        if (wr_unlock) begin
            nxt_unlock = hwdata[`SSS_UNLOCK_BIT];
        end
        if (strap_ff.operating_mode_strap == `SSS_MODE_REDUCED) begin
            nxt_efifo = EFIFO_REDUCED[EFIFO_W-1:0]; // [R9]
        end else begin
            nxt_efifo = EFIFO_NORMAL[EFIFO_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            lock_ff   <= `SSS_LOCK_RST; // [R7]
            marker_ff <= `SSS_MARKER_RST; // [R8]
            unlock_ff <= `SSS_UNLOCK_RST;
            efifo_ff  <= EFIFO_NORMAL[EFIFO_W-1:0];
        end else begin
            lock_ff   <= nxt_lock;
            marker_ff <= nxt_marker;
            unlock_ff <= nxt_unlock;
            efifo_ff  <= nxt_efifo;
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    sss_pkg::sss_status_s status_word;
    logic                 accept;
    logic                 nxt_wr_pend;
    logic [11:0]          nxt_wr_addr;
    logic [31:0]          rdata_ff;
    logic [31:0]          nxt_rdata;
    logic                 ready_ff;
    logic                 hresp_ff;

    always_comb begin
        status_word                      = '0; // [R12]
        status_word.operating_mode_strap = strap_ff.operating_mode_strap; // [R1]
        status_word.common_clock_down    = strap_ff.common_clock_down; // [R2]
        status_word.common_clock_up      = strap_ff.common_clock_up; // [R3]
        status_word.master_twowire_slow  = strap_ff.master_twowire_slow; // [R4]
        status_word.refclk_mode_select   = strap_ff.refclk_mode_select; // [R5]
        status_word.reset_halt_strap     = strap_ff.reset_halt_strap; // [R6]
        status_word.upstream_lock_state  = lock_ff; // [R7]
        status_word.marker               = marker_ff;
    end

    always_comb begin
        accept      = hsel && htrans[1] && hready;
        nxt_wr_pend = accept && hwrite && (hsize == `SSS_HSIZE_WORD);
        nxt_wr_addr = haddr[11:0];
        nxt_rdata   = 32'h0000_0000;
        if (accept && !hwrite) begin
            if (haddr[11:2] == `SSS_STATUS_OFF >> 2) begin
                nxt_rdata = status_word;
            end else if (haddr[11:2] == `SSS_UNLOCK_OFF >> 2) begin
                nxt_rdata[`SSS_UNLOCK_BIT] = unlock_ff;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
            rdata_ff   <= 32'h0000_0000;
            ready_ff   <= 1'b1;
            hresp_ff   <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rdata_ff   <= nxt_rdata;
            ready_ff   <= 1'b1;
            hresp_ff   <= 1'b0;
        end
    end

    assign hreadyout                  = ready_ff;
    assign hrdata                     = rdata_ff;
    assign hresp                      = hresp_ff;
    assign elastic_fifo_initial_value = efifo_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_MODE_FROZEN: assert property ($past(rstn) |-> $stable(strap_ff.operating_mode_strap)) // [R1]
        else $error("Mode strap changed outside reset");
    AST_CCLK_DOWN_FROZEN: assert property ($past(rstn) |-> $stable(strap_ff.common_clock_down)) // [R2]
        else $error("Downstream clock strap changed outside reset");
    AST_CCLK_UP_FROZEN: assert property ($past(rstn) |-> $stable(strap_ff.common_clock_up)) // [R3]
        else $error("Upstream clock strap changed outside reset");
    AST_SLOW_FROZEN: assert property ($past(rstn) |-> $stable(strap_ff.master_twowire_slow)) // [R4]
        else $error("Slow mode strap changed outside reset");
    AST_REFCLK_FROZEN: assert property ($past(rstn) |-> $stable(strap_ff.refclk_mode_select)) // [R5]
        else $error("Refclk strap changed outside reset");
    AST_HALT_READ: assert property (accept && !hwrite && haddr[11:2] == `SSS_STATUS_OFF >> 2
        |=> hrdata[`SSS_HALT_BIT] == strap_ff.reset_halt_strap) // [R6]
        else $error("Halt strap not reported");
    AST_LOCK_READ: assert property (accept && !hwrite && haddr[11:2] == `SSS_STATUS_OFF >> 2
        ##1 $past(rstn, 2) |-> hrdata[`SSS_LOCK_MSB:`SSS_LOCK_LSB] == $past(upstream_lock_state, 2)) // [R7]
        else $error("Lock state not reported");
    AST_MARKER_HOT: assert property (hot_reset && !wr_status |=> $stable(marker_ff)) // [R8]
        else $error("Marker changed by hot reset");
    AST_EFIFO_MODE: assert property ($past(rstn) |-> elastic_fifo_initial_value == ($past(
        strap_ff.operating_mode_strap) == `SSS_MODE_REDUCED ? EFIFO_REDUCED[EFIFO_W-1:0]
        : EFIFO_NORMAL[EFIFO_W-1:0])) // [R9]
        else $error("Elastic FIFO value wrong for mode");
    AST_MARKER_LOCKED: assert property (!unlock_ff |=> $stable(marker_ff)) // [R11]
        else $error("Marker written while locked");
    AST_RSVD_ZERO: assert property (hrdata[19:10] == 10'h000 && hrdata[27:23] == 5'h00
        && hrdata[4] == 1'b0) // [R12]
        else $error("Reserved bits read nonzero");

    COV_MARKER_WRITE: cover property (wr_status && unlock_ff ##1 marker_ff != $past(marker_ff));
    COV_LOCKED_WRITE: cover property (wr_status && !unlock_ff);
    COV_HOT_RESET: cover property (hot_reset && marker_ff != 4'h0);
    COV_REDUCED: cover property (elastic_fifo_initial_value == EFIFO_REDUCED[EFIFO_W-1:0]);

endmodule

// *** src/sss_cfg.svh ***
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SSS_STATUS_OFF      12'h328
`define SSS_UNLOCK_OFF      12'h3f0

// ****************************************
// Status field positions
// ****************************************
`define SSS_MODE_LSB        0
`define SSS_MODE_MSB        2
`define SSS_CCLK_DOWN_BIT   5
`define SSS_CCLK_UP_BIT     6
`define SSS_TW_SLOW_BIT     7
`define SSS_REFCLK_BIT      8
`define SSS_HALT_BIT        9
`define SSS_LOCK_LSB        20
`define SSS_LOCK_MSB        22
`define SSS_MARKER_LSB      28
`define SSS_MARKER_MSB      31
`define SSS_UNLOCK_BIT      3

// ****************************************
// Reset values and mode codes
// ****************************************
`define SSS_LOCK_RST        3'h0
`define SSS_MARKER_RST      4'h0
`define SSS_UNLOCK_RST      1'h0
`define SSS_MODE_REDUCED    3'h2
`define SSS_EFIFO_NORMAL    4'h4
`define SSS_EFIFO_REDUCED   4'h2
`define SSS_HSIZE_WORD      3'h2

`endif

// *** src/sss_pkg.sv ***
package sss_pkg;

    // ****************************************
    // Operating mode codes
    // ****************************************
    typedef enum logic [2:0] {
        SSS_MODE_NORMAL  = 3'b000,
        SSS_MODE_EEPROM1 = 3'b001,
        SSS_MODE_EEPROM2 = 3'b010,
        SSS_MODE_EEPROM3 = 3'b011
    } sss_mode_e;

    // ****************************************
    // Upstream lock codes
    // ****************************************
    typedef enum logic [2:0] {
        SSS_LOCK_NONE  = 3'b000,
        SSS_LOCK_PORT2 = 3'b010,
        SSS_LOCK_PORT3 = 3'b011,
        SSS_LOCK_PORT4 = 3'b100,
        SSS_LOCK_PORT5 = 3'b101
    } sss_lock_e;

    // ****************************************
    // Captured straps
    // ****************************************
    typedef struct packed {
        logic       reset_halt_strap;
        logic       refclk_mode_select;
        logic       master_twowire_slow;
        logic       common_clock_up;
        logic       common_clock_down;
        logic [2:0] operating_mode_strap;
    } sss_strap_s;

    // ****************************************
    // Status word layout
    // ****************************************
    typedef struct packed {
        logic [3:0] marker;
        logic [4:0] rsvd_27_23;
        logic [2:0] upstream_lock_state;
        logic [9:0] rsvd_19_10;
        logic       reset_halt_strap;
        logic       refclk_mode_select;
        logic       master_twowire_slow;
        logic       common_clock_up;
        logic       common_clock_down;
        logic [1:0] rsvd_4_3;
        logic [2:0] operating_mode_strap;
    } sss_status_s;

endpackage

// *** src/sss_sync.sv ***
`timescale 1ns/1ps

module sss_sync #(
    parameter int WIDTH = 8
) (
    // Clock
    input  wire logic             ref_clk,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    if (WIDTH < 1) begin : g_chk
        $error("sss_sync: WIDTH must be at least 1");
    end

    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    // Straps are sampled while reset is held, so no reset here
    always_ff @(posedge ref_clk) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign sync_out = sync_ff;

endmodule

// *** tb/tb_switch_status_register.sv ***
`timescale 1ns/1ps
`include "sss_cfg.svh"

module tb_switch_status_register;
    // ****************************************
    // Stimulus and observation
    // ****************************************
    localparam logic [31:0] STS = 32'h0000_0328;
    localparam logic [31:0] UNL = 32'h0000_03f0;
    logic        ref_clk     = 1'b0;
    logic        rstn        = 1'b0;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = 3'h2;
    logic [31:0] hwdata      = 32'h0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [7:0]  straps      = 8'h0;
    logic        hot_reset   = 1'b0;
    logic [2:0]  lock        = 3'h0;
    logic [3:0]  efifo;
    logic        rdy_q;
    logic [31:0] rd_q;
    logic [31:0] rd;
    logic [7:0]  s;
    logic [3:0]  mk;
    logic [31:0] w;
    logic [31:0] u;
    logic [2:0]  codes [5]   = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
    int          miscompares = 0;
    int          cmp_count   = 0;
    int          cycles      = 0;

    sss_switch_status DUT (
        .ref_clk                    (ref_clk),
        .rstn                       (rstn),
        .hsel                       (hsel),
        .haddr                      (haddr),
        .htrans                     (htrans),
        .hwrite                     (hwrite),
        .hsize                      (hsize),
        .hwdata                     (hwdata),
        .hready                     (hreadyout),
        .hreadyout                  (hreadyout),
        .hrdata                     (hrdata),
        .hresp                      (hresp),
        .operating_mode_strap       (straps[2:0]),
        .common_clock_down          (straps[3]),
        .common_clock_up            (straps[4]),
        .master_twowire_slow        (straps[5]),
        .refclk_mode_select         (straps[6]),
        .reset_halt_strap           (straps[7]),
        .hot_reset                  (hot_reset),
        .upstream_lock_state        (lock),
        .elastic_fifo_initial_value (efifo)
    );

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Values as sampled at each rising edge
    always @(posedge ref_clk) begin
        rdy_q  <= hreadyout;
        rd_q   <= hrdata;
        cycles <= cycles + 1;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] exp_sts(logic [7:0] st, logic [2:0] lk, logic [3:0] m);
        return {m, 5'h0, lk, 10'h0, st[7:3], 2'h0, st[2:0]};
    endfunction

    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Single AHB-Lite word transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= `SSS_HSIZE_WORD;
        do begin
            tick(1);
        end while (rdy_q !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            tick(1);
        end while (rdy_q !== 1'b1);
        rd = rd_q;
    endtask

    task automatic do_reset(input logic [7:0] st);
        rstn   <= 1'b0;
        straps <= st;
        lock   <= 3'h0;
        tick(20);
        rstn <= 1'b1;
        tick(1);
    endtask

    // Hang guard
    initial begin
        wait (cycles == 5000);
        miscompares++;
        give_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h1d407e1d));
        for (int m = 0; m < 4; m++) begin
            s = {5'($urandom), 3'(m)};
            if (m == 2) begin
                s[4:3] = 2'b11;
            end
            do_reset(s);
            chk("efifo", 32'(efifo), 32'((m == 2) ? `SSS_EFIFO_REDUCED : `SSS_EFIFO_NORMAL));
            ahb(1'b0, UNL, 32'($urandom));
            chk("unlock", {28'h0, rd[3], 3'h0}, 32'h0);
            straps <= ~s;
            tick(4);
            ahb(1'b0, STS, 32'($urandom));
            chk("status", rd, exp_sts(s, 3'h0, 4'h0));
            ahb(1'b1, STS, 32'($urandom) | 32'hf000_0000);
            ahb(1'b0, STS, 32'h0);
            chk("locked marker", rd, exp_sts(s, 3'h0, 4'h0));
            ahb(1'b1, UNL, 32'h0000_0008);
            mk = 4'($urandom);
            ahb(1'b1, STS, {mk, 28'($urandom)});
            ahb(1'b0, STS, 32'h0);
            chk("marker", rd, exp_sts(s, 3'h0, mk));
            hot_reset <= 1'b1;
            tick(3);
            hot_reset <= 1'b0;
            tick(2);
            ahb(1'b0, STS, 32'h0);
            chk("marker after hot reset", rd, exp_sts(s, 3'h0, mk));
        end
        for (int i = 0; i < 5; i++) begin
            lock <= codes[i];
            tick(2);
            ahb(1'b0, STS, 32'h0);
            chk("lock state", rd, exp_sts(s, codes[i], mk));
        end
        ahb(1'b0, 32'h0000_0324, 32'h0);
        chk("unmapped", rd, 32'h0);
        for (int i = 0; i < 30; i++) begin
            w = 32'($urandom);
            u = 32'($urandom);
            ahb(1'b1, UNL, u);
            ahb(1'b0, UNL, 32'h0);
            chk("random unlock", {28'h0, rd[3], 3'h0}, {28'h0, u[3], 3'h0});
            ahb(1'b1, STS, w);
            if (u[3] === 1'b1) begin
                mk = w[31:28];
            end
            ahb(1'b0, STS, 32'($urandom));
            chk("random marker", rd, exp_sts(s, 3'h5, mk));
        end
        give_verdict();
    end
endmodule
